// ### dpal_channel.sv
/*
 * One alarm channel: trip detection with hysteresis, delay, silence.
 * Assumes a one-cycle second tick and a blink level from the top.
 */
`timescale 1ns/100ps
`include "dpal_defines.svh"
module dpal_channel
   import dpal_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic                 secTick,
   input  wire logic                 blink,
   input  wire logic                 acceptPulse,
   input  wire dpal_pkg::dpal_value_t displayValue,
   input  wire logic                 channelEnableSetting,
   input  wire logic                 highLowSelect,
   input  wire logic                 closedWhenNormal,
   input  wire dpal_pkg::dpal_value_t setpoint,
   input  wire dpal_pkg::dpal_value_t hysteresisValue,
   input  wire dpal_pkg::dpal_secs_t  activationDelay,
   input  wire dpal_pkg::dpal_secs_t  silenceTime,
   output logic                      switchClosed,
   output logic                      annunciator,
   output logic                      outputActive,
   output logic                      alarmEvent
);
   dpal_state_t state;
   dpal_state_t next_state;
   dpal_secs_t  count;
   logic        tripped;
   logic        cleared;
   logic signed [`DPAL_VAL_W:0] lowLimit;
   logic signed [`DPAL_VAL_W:0] highLimit;

   // *************************************************************
   // comparison
   // *************************************************************
   // one extra bit keeps setpoint +/- hysteresis from wrapping
   assign lowLimit  = setpoint - hysteresisValue;
   assign highLimit = setpoint + hysteresisValue;
   assign tripped = highLowSelect ? (displayValue >= setpoint)
                                  : (displayValue <= setpoint);
   assign cleared = highLowSelect ? (displayValue < lowLimit)
                                  : (displayValue > highLimit);

   // *************************************************************
   // channel sequencing
   // *************************************************************
   always_comb
   begin
      next_state = state;
      unique case (state)
         DPAL_IDLE:
            if (tripped)
               next_state = (activationDelay == '0) ? DPAL_ACTIVE
                                                    : DPAL_DELAY;
         DPAL_DELAY:
            if (!tripped)
               next_state = DPAL_IDLE;
            else if (secTick && count == activationDelay - 1'b1)
               next_state = DPAL_ACTIVE;
         DPAL_ACTIVE:
            if (cleared)
               next_state = DPAL_IDLE;
            else if (acceptPulse && silenceTime != '0)
               next_state = DPAL_SILENCE;
         DPAL_SILENCE:
            if (cleared)
               next_state = DPAL_IDLE;
            else if (secTick && count == silenceTime - 1'b1)
               next_state = DPAL_ACTIVE;
         default:
            next_state = DPAL_IDLE;
      endcase
      if (!channelEnableSetting)
         next_state = DPAL_IDLE;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= DPAL_IDLE;
      else
         state <= next_state;
   end

   // seconds counter restarts on every state change
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         count <= '0;
      else if (next_state != state)
         count <= '0;
      else if (secTick)
         count <= count + 1'b1;
   end

   // *************************************************************
   // outputs
   // *************************************************************
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         outputActive <= 1'b0;
         switchClosed <= 1'b0;
         annunciator  <= 1'b0;
         alarmEvent   <= 1'b0;
      end
      else
      begin
         outputActive <= (next_state == DPAL_ACTIVE);
         switchClosed <= closedWhenNormal ^ (next_state == DPAL_ACTIVE);
         annunciator  <= (next_state == DPAL_ACTIVE) ||
                         ((next_state == DPAL_DELAY ||
                           next_state == DPAL_SILENCE) && blink);
         alarmEvent   <= (next_state == DPAL_ACTIVE) &&
                         (state != DPAL_ACTIVE);
      end
   end
endmodule

// ### dpal_defines.svh
/*
 * Constants for the dual process alarm logic.
 * Assumes one free-running ref_clk at 125 MHz and an async active-low reset.
 */
`ifndef DPAL_DEFINES_SVH
`define DPAL_DEFINES_SVH
`define DPAL_CLK_HZ        125000000
`define DPAL_SEC_CYCLES    (`DPAL_CLK_HZ)
`define DPAL_MAX_SECONDS   12'hE10
`define DPAL_BLINK_CYCLES  (`DPAL_CLK_HZ / 4)
`define DPAL_ALT_CYCLES    (`DPAL_CLK_HZ)
`define DPAL_VAL_W         20
`define DPAL_SEC_W         12
`endif

// ### dpal_field_model.sv
/*
 * Field side model: process value source with tare, and accept button.
 * Assumes the bench changes its commands only just after rising edges.
 */
`timescale 1ns/100ps
module dpal_field_model
   import dpal_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire dpal_pkg::dpal_value_t rawValue,
   input  wire dpal_pkg::dpal_value_t tareOffset,
   input  wire logic                  pressAccept,
   output dpal_pkg::dpal_value_t      displayValuePin,
   output logic                       acceptButton
);
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         displayValuePin <= '0;
      else
         displayValuePin <= rawValue + tareOffset;

   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         acceptButton <= 1'b0;
      else
         acceptButton <= pressAccept;
endmodule

// ### dpal_pkg.sv
/*
 * Types shared by the dual process alarm logic.
 * Assumes dpal_defines.svh is on the include path.
 */
`include "dpal_defines.svh"
package dpal_pkg;
   typedef logic signed [`DPAL_VAL_W-1:0] dpal_value_t;
   typedef logic [`DPAL_SEC_W-1:0]        dpal_secs_t;
   // channel states, one-hot
   typedef enum logic [3:0] {
      DPAL_IDLE    = 4'h1,
      DPAL_DELAY   = 4'h2,
      DPAL_ACTIVE  = 4'h4,
      DPAL_SILENCE = 4'h8
   } dpal_state_t;
   // what the display shows
   typedef enum logic [1:0] {
      DPAL_SHOW_VALUE = 2'h0,
      DPAL_SHOW_REF1  = 2'h1,
      DPAL_SHOW_REF2  = 2'h2
   } dpal_show_t;
endpackage

// ### dpal_top.sv
/*
 * Dual process alarm logic with APB register access and one interrupt.
 * Assumes display value and accept button come from outside the clock
 * domain; the APB master runs on ref_clk.
 */
`timescale 1ns/100ps
`include "dpal_defines.svh"
module dpal_top
   import dpal_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire dpal_pkg::dpal_value_t displayValuePin,
   input  wire logic                 acceptButton,
   output logic [1:0]                switchClosed,
   output logic [1:0]                annunciator,
   output dpal_pkg::dpal_show_t      showSelect,
   output logic                      irq
);
   localparam logic [11:0] OFS_GLOBAL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_MASK   = 12'h008;
   localparam logic [11:0] OFS_LIVE   = 12'h00C;
   localparam logic [11:0] OFS_CH0    = 12'h010;
   localparam logic [11:0] OFS_CH1    = 12'h020;

   dpal_value_t valSync1;
   dpal_value_t displayValue;
   logic        accSync1;
   logic        accSync2;
   logic        accLast;
   logic        acceptPulse;
   logic [26:0] secCnt;
   logic [24:0] blinkCnt;
   logic [26:0] altCnt;
   logic        secTick;
   logic        blink;
   logic        altPhase;
   logic        flashOnAlarm;
   logic [1:0]  status;
   logic [1:0]  next_status;
   logic [1:0]  mask;
   logic [1:0]  outputActive;
   logic [1:0]  alarmEvent;
   logic        acc;
   logic        statusRead;
   logic [1:0]  chEnable;
   logic [1:0]  chHigh;
   logic [1:0]  chClosed;
   dpal_value_t setpoint    [2];
   dpal_value_t hysteresis  [2];
   dpal_secs_t  delaySecs   [2];
   dpal_secs_t  silenceSecs [2];

   // register group decode, shared by read and write paths
   function automatic logic [2:0] regIdx(input logic [11:0] a, input int ch);
      logic [11:0] base;
      base = (ch == 0) ? OFS_CH0 : OFS_CH1;
      if (a[11:4] == base[11:4])
         regIdx = {1'b1, a[3:2]};
      else
         regIdx = 3'h0;
   endfunction

   function automatic dpal_secs_t clampSecs(input logic [31:0] d);
      if (d[`DPAL_SEC_W-1:0] > `DPAL_MAX_SECONDS || d[31:`DPAL_SEC_W] != '0)
         clampSecs = `DPAL_MAX_SECONDS;
      else
         clampSecs = d[`DPAL_SEC_W-1:0];
   endfunction

   // *************************************************************
   // input synchronisers
   // *************************************************************
   // a multi-bit value may tear over one edge; the display source is slow
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         valSync1     <= '0;
         displayValue <= '0;
         accSync1     <= 1'b0;
         accSync2     <= 1'b0;
         accLast      <= 1'b0;
      end
      else
      begin
         valSync1     <= displayValuePin;
         displayValue <= valSync1;
         accSync1     <= acceptButton;
         accSync2     <= accSync1;
         accLast      <= accSync2;
      end
   end
   assign acceptPulse = accSync2 && !accLast;

   // *************************************************************
   // time base
   // *************************************************************
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         secCnt <= '0;
      else
         secCnt <= secTick ? '0 : secCnt + 1'b1;
   end
   assign secTick = (secCnt == 27'(`DPAL_SEC_CYCLES - 1));

   // free-running, so the first flash after a trip may be short
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         blinkCnt <= '0;
         blink    <= 1'b0;
      end
      else if (blinkCnt == 25'(`DPAL_BLINK_CYCLES - 1))
      begin
         blinkCnt <= '0;
         blink    <= !blink;
      end
      else
         blinkCnt <= blinkCnt + 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         altCnt   <= '0;
         altPhase <= 1'b0;
      end
      else if (altCnt == 27'(`DPAL_ALT_CYCLES - 1))
      begin
         altCnt   <= '0;
         altPhase <= !altPhase;
      end
      else
         altCnt <= altCnt + 1'b1;
   end

   // *************************************************************
   // channels
   // *************************************************************
   // two channels
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gen_ch
         dpal_channel u_ch (
            .ref_clk              (ref_clk),
            .rst_n                (rst_n),
            .secTick              (secTick),
            .blink                (blink),
            .acceptPulse          (acceptPulse),
            .displayValue         (displayValue),
            .channelEnableSetting (chEnable[g]),
            .highLowSelect        (chHigh[g]),
            .closedWhenNormal     (chClosed[g]),
            .setpoint             (setpoint[g]),
            .hysteresisValue      (hysteresis[g]),
            .activationDelay      (delaySecs[g]),
            .silenceTime          (silenceSecs[g]),
            .switchClosed         (switchClosed[g]),
            .annunciator          (annunciator[g]),
            .outputActive         (outputActive[g]),
            .alarmEvent           (alarmEvent[g])
         );
      end
   endgenerate

   // *************************************************************
   // display alternation
   // *************************************************************
   // alternate value and reference
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         showSelect <= DPAL_SHOW_VALUE;
      else if (!flashOnAlarm || outputActive == 2'h0 || !altPhase)
         showSelect <= DPAL_SHOW_VALUE;
      else if (outputActive == 2'h3)
         showSelect <= blink ? DPAL_SHOW_REF2 : DPAL_SHOW_REF1;
      else
         showSelect <= outputActive[1] ? DPAL_SHOW_REF2 : DPAL_SHOW_REF1;
   end

   // *************************************************************
   // APB register file
   // *************************************************************
   assign acc        = psel && penable;
   assign pready     = 1'b1;
   assign pslverr    = 1'b0;
   assign statusRead = acc && !pwrite && paddr == OFS_STATUS;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         flashOnAlarm <= 1'b0;
      else if (acc && pwrite && paddr == OFS_GLOBAL)
         flashOnAlarm <= pwdata[0];
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         mask <= 2'h0;
      else if (acc && pwrite && paddr == OFS_MASK)
         mask <= pwdata[1:0];
   end

   generate
      for (g = 0; g < 2; g++)
      begin : gen_regs
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               chEnable[g]    <= 1'b0;
               chHigh[g]      <= 1'b1;
               chClosed[g]    <= 1'b0;
               setpoint[g]    <= '0;
               hysteresis[g]  <= '0;
               delaySecs[g]   <= '0;
               silenceSecs[g] <= '0;
            end
            else if (acc && pwrite)
            begin
               unique case (regIdx(paddr, g))
                  3'h4:
                  begin
                     chEnable[g] <= pwdata[0];
                     chHigh[g]   <= pwdata[1];
                     chClosed[g] <= pwdata[2];
                  end
                  3'h5: setpoint[g]    <= pwdata[`DPAL_VAL_W-1:0];
                  3'h6: hysteresis[g]  <= pwdata[`DPAL_VAL_W-1:0];
                  3'h7:
                  begin
                     delaySecs[g]   <= clampSecs({16'h0, pwdata[15:0]});
                     silenceSecs[g] <= clampSecs({16'h0, pwdata[31:16]});
                  end
                  default: ;
               endcase
            end
         end
      end
   endgenerate

   // sticky status: a new event beats the clearing read
   assign next_status = (statusRead ? 2'h0 : status) | alarmEvent;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         status <= 2'h0;
      else
         status <= next_status;
   end

   // irq is registered from next_status, so a read racing an event keeps it
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(next_status & mask);
   end

   function automatic logic [31:0] chRead(input logic [1:0] r, input int c);
      unique case (r)
         2'h0: chRead = {29'h0, chClosed[c], chHigh[c], chEnable[c]};
         2'h1: chRead = 32'(setpoint[c]);
         2'h2: chRead = 32'(hysteresis[c]);
         default: chRead = {4'h0, silenceSecs[c], 4'h0, delaySecs[c]};
      endcase
   endfunction

   always_comb
   begin
      prdata = 32'h0;
      if (psel && !pwrite)
      begin
         if (paddr == OFS_GLOBAL)
            prdata = {31'h0, flashOnAlarm};
         else if (paddr == OFS_STATUS)
            prdata = {30'h0, status};
         else if (paddr == OFS_MASK)
            prdata = {30'h0, mask};
         else if (paddr == OFS_LIVE)
            prdata = {28'h0, annunciator, outputActive};
         else if (regIdx(paddr, 0) != 3'h0)
            prdata = chRead(paddr[3:2], 0);
         else if (regIdx(paddr, 1) != 3'h0)
            prdata = chRead(paddr[3:2], 1);
      end
   end
endmodule

// ### dpal_top_props.sv
/*
 * Port relations of dpal_top, checked by concurrent assertions.
 * Assumes binding into dpal_top, one clock domain, async low reset.
 */
`timescale 1ns/100ps
module dpal_top_props
   import dpal_pkg::*;
(
   input wire logic                  ref_clk,
   input wire logic                  rst_n,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire dpal_pkg::dpal_value_t displayValuePin,
   input wire logic                  acceptButton,
   input wire logic [1:0]            switchClosed,
   input wire logic [1:0]            annunciator,
   input wire dpal_pkg::dpal_show_t  showSelect,
   input wire logic                  irq
);
   wire logic acc = psel && penable;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   ready_zero_wait_a: assert property (acc |-> pready)
      else $error("pready low in access phase");
   no_slave_err_a: assert property (acc |-> !pslverr)
      else $error("pslverr raised");
   idle_read_zero_a: assert property (!(psel && !pwrite) |-> prdata == 32'h0)
      else $error("prdata not zero outside a read");
   show_code_legal_a: assert property (showSelect != 2'h3)
      else $error("illegal display selection");
   // the selection lags the channel outputs by one register stage
   ref_one_ann_a:
      assert property (showSelect == DPAL_SHOW_REF1 |-> $past(annunciator[0]))
      else $error("first reference shown without alarm");
   ref_two_ann_a:
      assert property (showSelect == DPAL_SHOW_REF2 |-> $past(annunciator[1]))
      else $error("second reference shown without alarm");
   // sticky status only drops by a bus access
   irq_clear_cause_a: assert property
      ($fell(irq) |-> $past(acc, 1) || $past(acc, 2))
      else $error("irq fell with no bus access");
   irq_raise_cause_a: assert property
      ($rose(irq) |-> annunciator != 2'h0 || $past(acc, 1) || $past(acc, 2))
      else $error("irq rose with no alarm or mask write");
endmodule

bind dpal_top dpal_top_props i_dpal_top_props (
   .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .displayValuePin(displayValuePin),
   .acceptButton(acceptButton), .switchClosed(switchClosed),
   .annunciator(annunciator), .showSelect(showSelect), .irq(irq));

// ### tb_dpal_top.sv
/*
 * Self-checking bench for dpal_top over APB with the field model.
 * Assumes second-long timers never expire here, so delays stay zero.
 */
`timescale 1ns/100ps
`define CHECK(g, e, m) begin checks++; if ((g) !== (e)) begin \
   miscompares++; $display("[ERR] %0t %s", $time, m); end end
module tb_dpal_top;
   import dpal_pkg::*;
   logic        ref_clk, rst_n, psel, penable, pwrite;
   logic        pready, pslverr, irq, acceptButton, pressAccept, hi, sense;
   logic [11:0] paddr, base;
   logic [31:0] pwdata, prdata, rdata;
   logic [1:0]  switchClosed, annunciator;
   dpal_show_t  showSelect;
   dpal_value_t displayValuePin, rawValue, tareOffset, sp, hy;
   logic [11:0] regAddr [12] = '{12'h000, 12'h008, 12'h00C, 12'h010,
      12'h014, 12'h018, 12'h01C, 12'h020, 12'h024, 12'h028, 12'h02C, 12'h100};
   integer      seed = 31403;
   int          miscompares = 0, checks = 0, cycles = 0;

   dpal_top i_dpal_top (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .displayValuePin(displayValuePin), .acceptButton(acceptButton),
      .switchClosed(switchClosed), .annunciator(annunciator),
      .showSelect(showSelect), .irq(irq));
   dpal_field_model i_dpal_field_model (.ref_clk(ref_clk), .rst_n(rst_n),
      .rawValue(rawValue), .tareOffset(tareOffset), .pressAccept(pressAccept),
      .displayValuePin(displayValuePin), .acceptButton(acceptButton));

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task end_of_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // generous ceiling: the whole sequence needs about 830 cycles
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         miscompares++;
         $display("[ERR] %0t timeout", $time);
         end_of_test();
      end
   end

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rdata = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // sync, state and output stages settle well inside this wait
   task automatic setv(input dpal_value_t v);
      rawValue <= v - tareOffset;
      repeat (12) @(posedge ref_clk);
   endtask

   function automatic logic exp_sw(input logic act, input logic s);
      return act ^ s;
   endfunction

   function automatic dpal_value_t edge_val(input logic h,
      input dpal_value_t s, input dpal_value_t d);
      return h ? s - d : s + d;
   endfunction

   task automatic chk(input int ch, input logic act, input logic s);
      `CHECK(switchClosed[ch], exp_sw(act, s), "switch state")
      `CHECK(annunciator[ch], act, "annunciator")
   endtask

   initial
   begin
      {psel, penable, pwrite, pressAccept, paddr, pwdata} = '0;
      rawValue   = '0;
      tareOffset = '0;
      rst_n      = 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      // ***************************************************
      // reset values, unmapped place, clamping
      // ***************************************************
      foreach (regAddr[i])
      begin
         apb(1'b0, regAddr[i], 32'h0);
         // channel control resets to high alarm, disabled
         `CHECK(rdata, (regAddr[i] == 12'h010 || regAddr[i] == 12'h020) ?
                32'h2 : 32'h0, "reset value")
      end
      apb(1'b1, 12'h100, 32'hFFFFFFFF);
      apb(1'b0, 12'h100, 32'h0);
      `CHECK(rdata, 32'h0, "unmapped write")
      apb(1'b1, 12'h01C, 32'h0FA00FA0);
      apb(1'b0, 12'h01C, 32'h0);
      `CHECK(rdata, 32'h0E100E10, "time clamp")
      apb(1'b1, 12'h01C, 32'h0);
      $display("test registers done");
      // ***************************************************
      // every channel, mode and sense
      // ***************************************************
      tareOffset <= dpal_value_t'($random(seed) % 1000);
      for (int ch = 0; ch < 2; ch++)
         for (int m = 0; m < 4; m++)
         begin
            base  = 12'h010 + 12'(ch * 16);
            sp    = dpal_value_t'($random(seed) % 100000);
            hy    = dpal_value_t'($random(seed) & 255);
            hi    = m[0];
            sense = m[1];
            apb(1'b1, base + 12'h4, 32'(sp));
            apb(1'b1, base + 12'h8, 32'(hy));
            apb(1'b1, base + 12'hC, 32'h0);
            // park the value off the trip point before enabling
            setv(edge_val(hi, sp, 1));
            apb(1'b1, base, {29'h0, sense, hi, 1'b1});
            repeat (4) @(posedge ref_clk);
            chk(ch, 1'b0, sense);
            setv(sp);
            chk(ch, 1'b1, sense);
            `CHECK(annunciator[1 - ch], 1'b0, "other channel")
            `CHECK(showSelect, DPAL_SHOW_VALUE, "flash off")
            setv(edge_val(hi, sp, hy));
            chk(ch, 1'b1, sense);
            apb(1'b1, base, {29'h0, sense, hi, 1'b0});
            repeat (4) @(posedge ref_clk);
            chk(ch, 1'b0, sense);
            apb(1'b0, base + 12'h4, 32'h0);
            `CHECK(rdata[19:0], sp, "setpoint kept")
            apb(1'b1, base, {29'h0, sense, hi, 1'b1});
            repeat (4) @(posedge ref_clk);
            chk(ch, hy == 0, sense);
            setv(edge_val(hi, sp, hy + 1));
            chk(ch, 1'b0, sense);
            apb(1'b1, base, 32'h0);
            $display("test channel %0d mode %0d done", ch, m);
         end
      // ***************************************************
      // interrupt, live state, accept with no silence
      // ***************************************************
      apb(1'b0, 12'h004, 32'h0);
      apb(1'b1, 12'h008, 32'h1);
      apb(1'b1, 12'h014, 32'h0);
      apb(1'b1, 12'h018, 32'h0);
      setv(-5);
      apb(1'b1, 12'h010, 32'h3);
      setv(0);
      `CHECK(irq, 1'b1, "irq raised")
      apb(1'b0, 12'h00C, 32'h0);
      `CHECK(rdata, 32'h5, "live state")
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      `CHECK(rdata, 32'h1, "flash setting")
      apb(1'b1, 12'h000, 32'h0);
      pressAccept <= 1'b1;
      repeat (8) @(posedge ref_clk);
      pressAccept <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(0, 1'b1, 1'b0);
      apb(1'b0, 12'h004, 32'h0);
      `CHECK(rdata, 32'h1, "status")
      repeat (2) @(posedge ref_clk);
      `CHECK(irq, 1'b0, "irq cleared")
      apb(1'b1, 12'h008, 32'h0);
      setv(-5);
      setv(0);
      `CHECK(irq, 1'b0, "irq masked")
      apb(1'b0, 12'h004, 32'h0);
      `CHECK(rdata, 32'h1, "masked status")
      $display("test interrupt done");
      end_of_test();
   end
endmodule
